// ===== dsa_pkg.sv
package dsa_pkg;
	// Register byte addresses
	localparam logic [6:0] ADDR_THR1  = 7'h40;
	localparam logic [6:0] ADDR_THR2  = 7'h42;
	localparam logic [6:0] ADDR_SPAN1 = 7'h44;
	localparam logic [6:0] ADDR_SPAN2 = 7'h46;
	localparam logic [6:0] ADDR_CTRL  = 7'h48;

	// Values after reset
	localparam logic [15:0] THR_RST  = 16'h0000;
	localparam logic [7:0]  SPAN_RST = 8'h00;
	localparam logic [15:0] CTRL_RST = 16'h0000;

	// Control field positions
	localparam int CTRL_SRC1_LSB = 8;
	localparam int CTRL_SRC2_LSB = 12;
	localparam int CTRL_DYN2     = 7;
	localparam int CTRL_DYN1     = 6;
	localparam int CTRL_POL2     = 5;
	localparam int CTRL_POL1     = 4;
	localparam int CTRL_FILT     = 3;
	localparam int CTRL_IND_EN   = 2;
	localparam int CTRL_IND_POL  = 1;
	localparam int CTRL_IND_SEL  = 0;

	// Diagnostic status flag positions
	localparam int DIAG_ALM1_BIT = 8;
	localparam int DIAG_ALM2_BIT = 9;

	// Source selection codes
	localparam logic [3:0] SRC_OFF = 4'h0;
	localparam logic [3:0] SRC_XR  = 4'h1;
	localparam logic [3:0] SRC_YR  = 4'h2;
	localparam logic [3:0] SRC_ZR  = 4'h3;
	localparam logic [3:0] SRC_XA  = 4'h4;
	localparam logic [3:0] SRC_YA  = 4'h5;
	localparam logic [3:0] SRC_ZA  = 4'h6;

	// History memory shape and fill counter
	localparam int HIST_AW    = 8;
	localparam int HIST_DEPTH = 256;
	localparam int DW         = 16;
	localparam logic [8:0] FILL_MAX = 9'h100;

	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_EVAL = 1'b1
	} dsa_state_t;
endpackage

// ===== dsa_hist_mem.sv
`timescale 1ns/10ps
module dsa_hist_mem
	import dsa_pkg::*;
(
	input  wire logic               sys_clk_i,
	input  wire logic               nrst_i,
	input  wire logic               we_i,
	input  wire logic [HIST_AW-1:0] waddr_i,
	input  wire logic [DW-1:0]      wdata_i,
	input  wire logic [HIST_AW-1:0] raddr_i,
	output logic      [DW-1:0]      rdata_o
);
	logic [DW-1:0] mem [HIST_DEPTH];

	// Sample history store with registered read port
	always_ff @(posedge sys_clk_i) begin
		if (we_i) begin
			mem[waddr_i] <= wdata_i;
		end
		if (!nrst_i) begin
			rdata_o <= '0;
		end else begin
			rdata_o <= mem[raddr_i];
		end
	end
endmodule

// ===== dsa_alarm_monitor.sv
`timescale 1ns/10ps
// Contract
// - Two alarm channels, each with own threshold, polarity and source.
// - Static mode compares selected word against threshold in configured direction.
// - Threshold uses the same signed format as the selected output word.
// - Dynamic mode checks change between samples spaced by the sample count.
// - Dynamic mode uses threshold magnitude as allowed change over the span.
// - Sample count is low byte only; zero and one both mean one sample.
// - Alarm two source is bits 15:12; zero disables, one to six pick outputs.
// - Alarm one source is bits 11:8 with the same codes.
// - Bits 7 and 6 pick dynamic (one) or static mode for alarms two, one.
// - Bit 5 set makes alarm two trigger above threshold, clear below.
// - Alarm flags appear as diagnostic status bits 9 and 8.
// - Low three control bits configure an indicator on line one or two.
// - Bit 4 set makes alarm one trigger above threshold, clear below.
// - Bit 3 selects filtered (one) or unfiltered (zero) source data.
// - Bit 2 enables the indicator; bit 1 sets its active level.
// - Bit 0 routes indicator to line two when set, line one when clear.
module dsa_alarm_monitor
	import dsa_pkg::*;
(
	input  wire logic        sys_clk_i,
	input  wire logic        nrst_i,
	input  wire logic        wr_i,
	input  wire logic [6:0]  wr_addr_i,
	input  wire logic [7:0]  wr_data_i,
	input  wire logic        rd_i,
	input  wire logic [6:0]  rd_addr_i,
	output logic      [15:0] rd_data_o,
	input  wire logic        sample_valid_i,
	input  wire logic [15:0] x_rate_output_filt_i,
	input  wire logic [15:0] y_rate_output_filt_i,
	input  wire logic [15:0] z_rate_output_filt_i,
	input  wire logic [15:0] x_accel_output_filt_i,
	input  wire logic [15:0] y_accel_output_filt_i,
	input  wire logic [15:0] z_accel_output_filt_i,
	input  wire logic [15:0] x_rate_output_raw_i,
	input  wire logic [15:0] y_rate_output_raw_i,
	input  wire logic [15:0] z_rate_output_raw_i,
	input  wire logic [15:0] x_accel_output_raw_i,
	input  wire logic [15:0] y_accel_output_raw_i,
	input  wire logic [15:0] z_accel_output_raw_i,
	output logic      [15:0] diagnostic_status_o,
	output logic             digital_line_one_o,
	output logic             digital_line_one_oe_o,
	output logic             digital_line_two_o,
	output logic             digital_line_two_oe_o
);
	// Select one output word by source code
	function automatic logic [15:0] dsa_pick(input logic [3:0] code, input logic [15:0] xr, input logic [15:0] yr,
		input logic [15:0] zr, input logic [15:0] xa, input logic [15:0] ya, input logic [15:0] za);
		case (code)
			SRC_XR:  return xr;
			SRC_YR:  return yr;
			SRC_ZR:  return zr;
			SRC_XA:  return xa;
			SRC_YA:  return ya;
			SRC_ZA:  return za;
			default: return 16'h0000;
		endcase
	endfunction
	// Magnitude of a 17-bit signed value
	function automatic logic [16:0] dsa_abs(input logic signed [16:0] v);
		return v[16] ? 17'(-v) : 17'(v);
	endfunction
	// Source code is live only for codes one to six
	function automatic logic dsa_src_on(input logic [3:0] code);
		return (code >= SRC_XR) && (code <= SRC_ZA);
	endfunction
	dsa_state_t         st, next_st;
	logic [15:0]        thr [2], next_thr [2];
	logic [7:0]         span [2], next_span [2];
	logic [15:0]        ctrl, next_ctrl;
	logic [15:0]        rd_data, next_rd_data;
	logic [15:0]        cur [2], next_cur [2];
	logic [8:0]         fill [2], next_fill [2];
	logic [1:0]         flag, next_flag;
	logic [7:0]         wptr, next_wptr;
	logic               line_lvl, next_line_lvl;
	logic               oe_one, next_oe_one;
	logic               oe_two, next_oe_two;
	logic [3:0]         src [2];
	logic               dyn [2], pol [2];
	logic [7:0]         eff_span [2];
	logic               ready [2];
	logic [15:0]        pick [2], hist_old [2];
	logic [HIST_AW-1:0] hist_raddr [2];
	logic               accept;
	logic [15:0]        sxr, syr, szr, sxa, sya, sza;

	// Control field decode per channel
	always_comb begin
		src[0] = ctrl[CTRL_SRC1_LSB +: 4];
		src[1] = ctrl[CTRL_SRC2_LSB +: 4];
		dyn[0] = ctrl[CTRL_DYN1];
		dyn[1] = ctrl[CTRL_DYN2];
		pol[0] = ctrl[CTRL_POL1];
		pol[1] = ctrl[CTRL_POL2];
		for (int c = 0; c < 2; c++) begin
			eff_span[c] = (span[c] == 8'h00) ? 8'h01 : span[c];
			ready[c]    = fill[c] > {1'b0, eff_span[c]};
			hist_raddr[c] = wptr - eff_span[c];
		end
	end

	// Filtered or unfiltered data feeds both channels
	assign sxr = ctrl[CTRL_FILT] ? x_rate_output_filt_i  : x_rate_output_raw_i;
	assign syr = ctrl[CTRL_FILT] ? y_rate_output_filt_i  : y_rate_output_raw_i;
	assign szr = ctrl[CTRL_FILT] ? z_rate_output_filt_i  : z_rate_output_raw_i;
	assign sxa = ctrl[CTRL_FILT] ? x_accel_output_filt_i : x_accel_output_raw_i;
	assign sya = ctrl[CTRL_FILT] ? y_accel_output_filt_i : y_accel_output_raw_i;
	assign sza = ctrl[CTRL_FILT] ? z_accel_output_filt_i : z_accel_output_raw_i;
	assign pick[0] = dsa_pick(src[0], sxr, syr, szr, sxa, sya, sza);
	assign pick[1] = dsa_pick(src[1], sxr, syr, szr, sxa, sya, sza);
	assign accept  = sample_valid_i && (st == ST_IDLE);
	// One history store per channel
	for (genvar g = 0; g < 2; g++) begin : g_hist
		dsa_hist_mem u_hist (
			.sys_clk_i (sys_clk_i),
			.nrst_i    (nrst_i),
			.we_i      (accept),
			.waddr_i   (wptr),
			.wdata_i   (pick[g]),
			.raddr_i   (hist_raddr[g]),
			.rdata_o   (hist_old[g])
		);
	end

	// Register writes, reads, sample capture and alarm evaluation
	always_comb begin
		logic [16:0] delta;
		logic [16:0] mag;
		logic        hit;
		logic        any;
		delta        = '0;
		mag          = '0;
		hit          = 1'b0;
		any          = 1'b0;
		next_st      = st;
		next_thr     = thr;
		next_span    = span;
		next_ctrl    = ctrl;
		next_rd_data = rd_data;
		next_cur     = cur;
		next_fill    = fill;
		next_flag    = flag;
		next_wptr    = wptr;
		if (wr_i) begin
			case (wr_addr_i[6:1])
				ADDR_THR1[6:1]:  if (wr_addr_i[0]) next_thr[0][15:8] = wr_data_i; else next_thr[0][7:0] = wr_data_i;
				ADDR_THR2[6:1]:  if (wr_addr_i[0]) next_thr[1][15:8] = wr_data_i; else next_thr[1][7:0] = wr_data_i;
				ADDR_SPAN1[6:1]: if (!wr_addr_i[0]) next_span[0] = wr_data_i;
				ADDR_SPAN2[6:1]: if (!wr_addr_i[0]) next_span[1] = wr_data_i;
				ADDR_CTRL[6:1]:  if (wr_addr_i[0]) next_ctrl[15:8] = wr_data_i; else next_ctrl[7:0] = wr_data_i;
				default: ;
			endcase
		end
		if (rd_i) begin
			case (rd_addr_i[6:1])
				ADDR_THR1[6:1]:  next_rd_data = thr[0];
				ADDR_THR2[6:1]:  next_rd_data = thr[1];
				ADDR_SPAN1[6:1]: next_rd_data = {8'h00, span[0]};
				ADDR_SPAN2[6:1]: next_rd_data = {8'h00, span[1]};
				ADDR_CTRL[6:1]:  next_rd_data = ctrl;
				default:         next_rd_data = 16'h0000;
			endcase
		end
		case (st)
			ST_IDLE: begin
				if (sample_valid_i) begin
					next_cur  = pick;
					next_wptr = wptr + 8'h01;
					for (int c = 0; c < 2; c++) begin
						next_fill[c] = (fill[c] == FILL_MAX) ? fill[c] : 9'(fill[c] + 9'h001);
					end
					next_st = ST_EVAL;
				end
			end
			ST_EVAL: begin
				for (int c = 0; c < 2; c++) begin
					delta = 17'({cur[c][15], cur[c]} - {hist_old[c][15], hist_old[c]});
					delta = dsa_abs(delta);
					mag   = dsa_abs({thr[c][15], thr[c]});
					if (!dsa_src_on(src[c])) begin
						hit = 1'b0;
					end else if (dyn[c]) begin
						hit = ready[c] && (pol[c] ? (delta > mag) : (delta < mag));
					end else begin
						hit = pol[c] ? ($signed(cur[c]) > $signed(thr[c]))
						             : ($signed(cur[c]) < $signed(thr[c]));
					end
					next_flag[c] = hit;
				end
				next_st = ST_IDLE;
			end
			default: next_st = ST_IDLE;
		endcase
		// Any change to configuration restarts the history
		if (wr_i) begin
			next_fill = '{default: 9'h000};
		end
		any           = |next_flag;
		next_line_lvl = ctrl[CTRL_IND_POL] ? any : !any;
		next_oe_one   = ctrl[CTRL_IND_EN] && !ctrl[CTRL_IND_SEL];
		next_oe_two   = ctrl[CTRL_IND_EN] && ctrl[CTRL_IND_SEL];
	end

	// State registers
	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			st       <= ST_IDLE;
			thr      <= '{default: THR_RST};
			span     <= '{default: SPAN_RST};
			ctrl     <= CTRL_RST;
			rd_data  <= 16'h0000;
			cur      <= '{default: 16'h0000};
			fill     <= '{default: 9'h000};
			flag     <= 2'h0;
			wptr     <= 8'h00;
			line_lvl <= 1'b0;
			oe_one   <= 1'b0;
			oe_two   <= 1'b0;
		end else begin
			st       <= next_st;
			thr      <= next_thr;
			span     <= next_span;
			ctrl     <= next_ctrl;
			rd_data  <= next_rd_data;
			cur      <= next_cur;
			fill     <= next_fill;
			flag     <= next_flag;
			wptr     <= next_wptr;
			line_lvl <= next_line_lvl;
			oe_one   <= next_oe_one;
			oe_two   <= next_oe_two;
		end
	end

	// Outputs
	assign rd_data_o             = rd_data;
	assign diagnostic_status_o   = {6'h00, flag[1], flag[0], 8'h00};
	assign digital_line_one_o    = line_lvl;
	assign digital_line_two_o    = line_lvl;
	assign digital_line_one_oe_o = oe_one;
	assign digital_line_two_oe_o = oe_two;
	// Checks, all on the system clock and quiet in reset
	default clocking dsa_cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!nrst_i);
	property p_disabled_quiet;
		(st == ST_EVAL && src[0] == SRC_OFF) |=> !diagnostic_status_o[DIAG_ALM1_BIT];
	endproperty
	a_disabled_quiet: assert property (p_disabled_quiet) else $error("disabled alarm one flagged");
	property p_static_gt;
		(st == ST_EVAL && dsa_src_on(src[0]) && !dyn[0] && pol[0] && $signed(cur[0]) > $signed(thr[0]))
		|=> diagnostic_status_o[DIAG_ALM1_BIT];
	endproperty
	a_static_gt: assert property (p_static_gt) else $error("static above-threshold alarm missed");
	property p_static_lt;
		(st == ST_EVAL && dsa_src_on(src[1]) && !dyn[1] && !pol[1] && !($signed(cur[1]) < $signed(thr[1])))
		|=> !diagnostic_status_o[DIAG_ALM2_BIT];
	endproperty
	a_static_lt: assert property (p_static_lt) else $error("static below alarm raised wrongly");
	property p_eval_latency;
		accept |=> (st == ST_EVAL) ##1 (st == ST_IDLE);
	endproperty
	a_eval_latency: assert property (p_eval_latency) else $error("sample not evaluated in two cycles");
	property p_route_two;
		(ctrl[CTRL_IND_EN] && ctrl[CTRL_IND_SEL]) [*2] |-> (digital_line_two_oe_o && !digital_line_one_oe_o);
	endproperty
	a_route_two: assert property (p_route_two) else $error("indicator not on line two");
	property p_ind_off;
		!ctrl[CTRL_IND_EN] [*2] |-> !(digital_line_one_oe_o || digital_line_two_oe_o);
	endproperty
	a_ind_off: assert property (p_ind_off) else $error("indicator driven while disabled");
	property p_flag_moves_on_eval;
		$changed(diagnostic_status_o[9:8]) |-> ($past(st) == ST_EVAL);
	endproperty
	a_flag_moves_on_eval: assert property (p_flag_moves_on_eval) else $error("flag moved off evaluation");
	property p_span_upper_zero;
		(rd_i && (rd_addr_i[6:1] == ADDR_SPAN1[6:1] || rd_addr_i[6:1] == ADDR_SPAN2[6:1]))
		|=> (rd_data_o[15:8] == 8'h00);
	endproperty
	a_span_upper_zero: assert property (p_span_upper_zero) else $error("span upper byte not zero");
	property p_dyn_not_ready;
		(st == ST_EVAL && dyn[0] && !ready[0]) |=> !diagnostic_status_o[DIAG_ALM1_BIT];
	endproperty
	a_dyn_not_ready: assert property (p_dyn_not_ready) else $error("dynamic alarm before span filled");
	property p_ind_level;
		($past(ctrl[CTRL_IND_POL]) && (|flag)) |-> (digital_line_one_o && digital_line_two_o);
	endproperty
	a_ind_level: assert property (p_ind_level) else $error("indicator level wrong for active alarm");
	c_static_hit: cover property ((st == ST_EVAL && !dyn[0]) ##1 diagnostic_status_o[DIAG_ALM1_BIT]);
	c_dynamic_hit: cover property ((st == ST_EVAL && dyn[1]) ##1 diagnostic_status_o[DIAG_ALM2_BIT]);
	c_line_two: cover property (digital_line_two_oe_o && (|flag));
endmodule

// ===== dsa_host_model.sv
`timescale 1ns/10ps
// Host processor side of the register port: byte writes, word reads
module dsa_host_model (
	input  wire logic        sys_clk_i,
	output logic             wr_o,
	output logic      [6:0]  wr_addr_o,
	output logic      [7:0]  wr_data_o,
	output logic             rd_o,
	output logic      [6:0]  rd_addr_o,
	input  wire logic [15:0] rd_data_i
);
	// Bus idle from time zero
	initial begin
		wr_o = 1'b0;
		wr_addr_o = 7'h00;
		wr_data_o = 8'h00;
		rd_o = 1'b0;
		rd_addr_o = 7'h00;
	end

	// Single byte write, strobe held for exactly one edge
	task automatic wr_byte(input logic [6:0] a, input logic [7:0] d);
		@(negedge sys_clk_i);
		wr_o = 1'b1;
		wr_addr_o = a;
		wr_data_o = d;
		@(negedge sys_clk_i);
		wr_o = 1'b0;
	endtask

	// Word write as two back-to-back bytes, high byte first
	// Thresholds go out as two's complement words, like the sensor words
	task automatic wr_word(input logic [6:0] a, input logic [15:0] d);
		@(negedge sys_clk_i);
		wr_o = 1'b1;
		wr_addr_o = a | 7'h01;
		wr_data_o = d[15:8];
		@(negedge sys_clk_i);
		wr_addr_o = a & 7'h7e;
		wr_data_o = d[7:0];
		@(negedge sys_clk_i);
		wr_o = 1'b0;
	endtask

	// Word read; data taken a cycle and a half after the strobe edge
	task automatic rd_word(input logic [6:0] a, output logic [15:0] d);
		@(negedge sys_clk_i);
		rd_o = 1'b1;
		rd_addr_o = a;
		@(negedge sys_clk_i);
		rd_o = 1'b0;
		@(negedge sys_clk_i);
		d = rd_data_i;
	endtask
endmodule

// ===== testbench.sv
`timescale 1ns/10ps
module testbench;
	import dsa_pkg::*;
	logic                sys_clk_i = 1'b0;
	logic                nrst_i = 1'b0;
	logic                sample_valid_i = 1'b0;
	logic                note_pulse = 1'b0;
	logic                wr_i, rd_i, ln1, oe1, ln2, oe2;
	logic [6:0]          wr_addr_i, rd_addr_i;
	logic [7:0]          wr_data_i;
	logic [15:0]         rd_data_o, diagnostic_status_o, ctrl;
	logic [15:0]         filt_w [6] = '{default: 16'h0000};
	logic [15:0]         raw_w [6] = '{default: 16'h0000};
	logic [15:0]         thr [2], span [2];
	logic signed [15:0]  hist [2][8];
	logic [19:0]         notes [$];
	logic [19:0]         w;
	logic [2:0]          pipe = 3'b000;
	logic [31:0]         seed = 32'h0000_1e0c;
	logic [31:0]         t;
	int                  cnt [2];
	int                  mismatches = 0;
	int                  checks = 0;

	always #2.5 sys_clk_i = ~sys_clk_i;

	dsa_host_model host (.sys_clk_i(sys_clk_i), .wr_o(wr_i), .wr_addr_o(wr_addr_i), .wr_data_o(wr_data_i),
		.rd_o(rd_i), .rd_addr_o(rd_addr_i), .rd_data_i(rd_data_o));

	dsa_alarm_monitor uut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .wr_i(wr_i), .wr_addr_i(wr_addr_i),
		.wr_data_i(wr_data_i), .rd_i(rd_i), .rd_addr_i(rd_addr_i), .rd_data_o(rd_data_o),
		.sample_valid_i(sample_valid_i), .x_rate_output_filt_i(filt_w[0]), .y_rate_output_filt_i(filt_w[1]),
		.z_rate_output_filt_i(filt_w[2]), .x_accel_output_filt_i(filt_w[3]), .y_accel_output_filt_i(filt_w[4]),
		.z_accel_output_filt_i(filt_w[5]), .x_rate_output_raw_i(raw_w[0]), .y_rate_output_raw_i(raw_w[1]),
		.z_rate_output_raw_i(raw_w[2]), .x_accel_output_raw_i(raw_w[3]), .y_accel_output_raw_i(raw_w[4]),
		.z_accel_output_raw_i(raw_w[5]), .diagnostic_status_o(diagnostic_status_o),
		.digital_line_one_o(ln1), .digital_line_one_oe_o(oe1),
		.digital_line_two_o(ln2), .digital_line_two_oe_o(oe2));

	// Fixed-seed pseudo random source
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// Compare and count
	task automatic check(input logic [19:0] seen, input logic [19:0] want);
		checks++;
		if (seen !== want) begin
			mismatches++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, want);
		end
	endtask

	// Verdict and end of run
	task automatic conclude();
		if (mismatches == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic rd_chk(input logic [6:0] a, input logic [15:0] want);
		logic [15:0] r;
		host.rd_word(a, r);
		check({4'h0, r}, {4'h0, want});
	endtask

	// Reference model of both channels for one new sample; notes the outcome
	task automatic predict();
		logic [3:0] s;
		logic signed [15:0] cur;
		logic [1:0] f;
		logic lv, ok;
		int d, m, n;
		for (int c = 0; c < 2; c++) begin
			s = ctrl[8 + 4 * c +: 4];
			cur = ctrl[3] ? filt_w[s - 4'h1] : raw_w[s - 4'h1];
			n = (span[c][7:0] < 8'h02) ? 1 : int'(span[c][7:0]);
			hist[c][cnt[c] % 8] = cur;
			cnt[c]++;
			d = cur;
			m = $signed(thr[c]);
			if (ctrl[6 + c]) begin
				d = cur - hist[c][(cnt[c] + 7 - n) % 8];
				d = (d < 0) ? -d : d;
				m = (m < 0) ? -m : m;
			end
			ok = (s inside {[4'h1 : 4'h6]}) && (!ctrl[6 + c] || cnt[c] > n);
			f[c] = ok && (ctrl[4 + c] ? d > m : d < m);
		end
		lv = (|f) ^ ~ctrl[1];
		notes.push_back({6'h00, f, 8'h00, lv, ctrl[2] & ~ctrl[0], lv, ctrl[2] & ctrl[0]});
	endtask

	// New sensor words and one sample strobe; optionally a refused second strobe
	task automatic sample(input logic twice);
		@(negedge sys_clk_i);
		for (int k = 0; k < 6; k++) begin
			t = xs();
			filt_w[k] = t[15:0];
			raw_w[k] = t[31:16];
		end
		sample_valid_i = 1'b1;
		note_pulse = 1'b1;
		predict();
		@(negedge sys_clk_i);
		note_pulse = 1'b0;
		sample_valid_i = twice;
		@(negedge sys_clk_i);
		sample_valid_i = 1'b0;
		repeat (2) @(negedge sys_clk_i);
	endtask

	// Watcher: result stands two edges after the taking edge
	always @(posedge sys_clk_i) pipe <= {pipe[1:0], note_pulse};
	always @(negedge sys_clk_i) begin
		if (pipe[2]) begin
			w = notes.pop_front();
			check({4'h0, diagnostic_status_o}, {4'h0, w[19:4]});
			check({16'h0000, ln1, oe1, ln2, oe2}, {16'h0000, w[3:0]});
		end
	end

	// Hang guard
	initial begin
		repeat (100000) @(posedge sys_clk_i);
		mismatches++;
		conclude();
	end

	// Main sequence
	initial begin
		repeat (2) @(negedge sys_clk_i);
		nrst_i = 1'b1;
		check({4'h0, diagnostic_status_o}, 20'h0_0000);
		check({16'h0000, ln1, oe1, ln2, oe2}, 20'h0_0000);
		for (int a = 'h40; a <= 'h4a; a += 2)
			rd_chk(7'(a), 16'h0000);
		host.wr_word(ADDR_SPAN1, 16'h0a03);
		host.wr_byte(7'h45, 8'hff);
		rd_chk(ADDR_SPAN1, 16'h0003);
		host.wr_word(ADDR_CTRL, 16'h36af);
		rd_chk(ADDR_CTRL, 16'h36af);
		host.wr_word(7'h4a, 16'hffff);
		rd_chk(7'h4a, 16'h0000);
		for (int i = 0; i < 48; i++) begin
			t = xs();
			ctrl = {4'((i + 3) % 8), 4'(i % 8), t[7:0]};
			t = xs();
			thr[0] = t[15:0];
			thr[1] = t[31:16];
			t = xs();
			span[0] = {t[15:8], 5'h00, t[2:0]};
			span[1] = {t[23:16], 5'h00, t[5:3]};
			host.wr_word(ADDR_THR1, thr[0]);
			host.wr_word(ADDR_THR2, thr[1]);
			host.wr_word(ADDR_SPAN1, span[0]);
			host.wr_word(ADDR_SPAN2, span[1]);
			host.wr_word(ADDR_CTRL, ctrl);
			cnt = '{0, 0};
			for (int k = 0; k < 12; k++)
				sample(k == 5);
		end
		repeat (4) @(negedge sys_clk_i);
		check(20'(notes.size()), 20'h0_0000);
		conclude();
	end
endmodule
